// ---- logic/timestamp_capture.sv ----
// per-port video timestamp capture with axi4-lite registers
//
// Contract
// - frame sync active edge is rising when polarity bit is 0, else falling.
// - resolution code 00/01/10/11 sets tick to 40ns/80ns/160ns/1us.
// - early-ready bit set flags ready once all enabled ports captured.
// - frame mode with free-run waits for programmed line, then frame edge.
// - writing hold to 1 freezes timestamps and clears ready at once.
// - control bits 1:0 enable capture per receive port.
// - line upper byte is a read/write register resetting to zero.
// - line lower byte is a separate register forming the low half.
// - read-only ready flag and per-port valid flags in status.
// - each port timestamp reads as upper and lower byte registers.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module timestamp_capture #(
  parameter int TS_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [ts_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ts_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic [1:0]              frame_sync,
  input  wire logic [1:0]              line_start,
  output logic                         irq
);

  // ==========================================================
  // address decode
  // register index match for a byte address
  function automatic logic hit(
    input logic [ts_pkg::ADDR_W-1:0] addr,
    input logic [7:0]                idx
  );
    hit = (addr[ts_pkg::ADDR_W-1:2] == idx);
  endfunction

  // any implemented register; others answer error
  function automatic logic mapped(
    input logic [ts_pkg::ADDR_W-1:0] addr
  );
    logic [7:0] i;
    i = addr[9:2];
    mapped = (i >= ts_pkg::IDX_CONFIG && i <= ts_pkg::IDX_TS_P1_LO) ||
             i == ts_pkg::IDX_IRQ_STS || i == ts_pkg::IDX_IRQ_MASK;
  endfunction

  // ==========================================================
  // state
  ts_pkg::cfg_s              cfg_r;
  ts_pkg::ctl_s              ctl_r;
  logic [7:0]                line_hi_r;
  logic [7:0]                line_lo_r;
  logic [TS_W-1:0]           ts_r [ts_pkg::NUM_PORTS];
  logic [1:0]                valid_r;
  logic                      ready_r;
  logic                      ready_nxt;
  logic [ts_pkg::IRQ_W-1:0]  irq_sts_r;
  logic [ts_pkg::IRQ_W-1:0]  irq_mask_r;
  logic [ts_pkg::IRQ_W-1:0]  irq_ev;
  // write channel holding registers
  logic [ts_pkg::ADDR_W-1:0] awaddr_r;
  logic [7:0]                wbyte_r;
  logic                      wstrb0_r;
  logic                      do_write;
  logic                      rd_take;
  logic [7:0]                rd_byte;
  // trigger side
  logic [TS_W-1:0]           ts_now;
  logic [1:0]                trig;
  logic [1:0]                edge_hit;
  logic [1:0]                en;
  logic [1:0]                cap;
  logic                      hold_set;
  logic                      hold_clr;
  logic                      all_done;

  // ==========================================================
  // timestamp counter
  tick_counter #(
    .TS_W (TS_W)
  ) u_tick (
    .clk                (clk),
    .rst_n              (rst_n),
    .tick_period_select (cfg_r.tick_period_select),
    .ts_value           (ts_now)
  );

  assign en = {ctl_r.port1_capture_enable, ctl_r.port0_capture_enable};

  // ==========================================================
  // per-port trigger logic
  genvar g;
  generate
    for (g = 0; g < ts_pkg::NUM_PORTS; g++) begin : g_port
      port_capture u_port (
        .clk                    (clk),
        .rst_n                  (rst_n),
        .frame_sync             (frame_sync[g]),
        .line_start             (line_start[g]),
        .enable                 (en[g]),
        .sync_edge_select       (cfg_r.sync_edge_select),
        .capture_trigger_select (cfg_r.capture_trigger_select),
        .free_running_select    (cfg_r.free_running_select),
        .capture_line           ({line_hi_r, line_lo_r}),
        .trig                   (trig[g]),
        .sync_edge              (edge_hit[g])
      );
    end
  endgenerate

  // ==========================================================
  // axi4-lite write channel
  // both halves in, no answer pending
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // address and data taken in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      awaddr_r      <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_r      <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // data half; only the low byte and strobe 0 matter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b1;
      wbyte_r      <= 8'h00;
      wstrb0_r     <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wbyte_r      <= s_axi_wdata[7:0];
      wstrb0_r     <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // response one cycle after both halves are in
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ts_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      // unmapped: nothing changes, error answered
      s_axi_bresp  <= mapped(awaddr_r) ? ts_pkg::RESP_OKAY
                                       : ts_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r      <= ts_pkg::CONFIG_RST;
      ctl_r      <= ts_pkg::CONTROL_RST;
      line_hi_r  <= ts_pkg::LINE_RST;
      line_lo_r  <= ts_pkg::LINE_RST;
      irq_mask_r <= ts_pkg::IRQ_MASK_RST[ts_pkg::IRQ_W-1:0];
    end else if (do_write && wstrb0_r) begin
      // reserved bits masked so they read zero
      if (hit(awaddr_r, ts_pkg::IDX_CONFIG))
        cfg_r <= wbyte_r & ts_pkg::CONFIG_WMASK;
      // enables and hold; hold edges decoded below
      if (hit(awaddr_r, ts_pkg::IDX_CONTROL))
        ctl_r <= wbyte_r & ts_pkg::CONTROL_WMASK;
      if (hit(awaddr_r, ts_pkg::IDX_LINE_HI))
        line_hi_r <= wbyte_r;
      if (hit(awaddr_r, ts_pkg::IDX_LINE_LO))
        line_lo_r <= wbyte_r;
      // mask shares the status layout
      if (hit(awaddr_r, ts_pkg::IDX_IRQ_MASK))
        irq_mask_r <= wbyte_r[ts_pkg::IRQ_W-1:0] &
                      ts_pkg::IRQ_WMASK[ts_pkg::IRQ_W-1:0];
    end
  end

  // ==========================================================
  // hold control edges
  // hold takes effect in the write cycle itself
  assign hold_set = do_write && wstrb0_r &&
                    hit(awaddr_r, ts_pkg::IDX_CONTROL) &&
                    wbyte_r[ts_pkg::HOLD_BIT] && !ctl_r.capture_hold;
  // release by software starts a fresh round
  assign hold_clr = do_write && wstrb0_r &&
                    hit(awaddr_r, ts_pkg::IDX_CONTROL) &&
                    !wbyte_r[ts_pkg::HOLD_BIT] && ctl_r.capture_hold;

  // captures ignored while frozen
  assign cap = trig & {2{!ctl_r.capture_hold && !hold_set}};

  // ==========================================================
  // captured values and valid flags
  // values only change while not frozen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ts_pkg::NUM_PORTS; i++)
        ts_r[i] <= '0;
    end else begin
      for (int i = 0; i < ts_pkg::NUM_PORTS; i++)
        if (cap[i])
          ts_r[i] <= ts_now;
    end
  end

  // valid set on capture, cleared on release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_r <= 2'b00;
    end else begin
      for (int i = 0; i < ts_pkg::NUM_PORTS; i++)
        if (cap[i])
          valid_r[i] <= 1'b1;
        else if (hold_clr)
          valid_r[i] <= 1'b0;
    end
  end

  // ==========================================================
  // ready flag
  // no enabled port means a round never completes
  assign all_done = |en && ((valid_r & en) == en);

  // hold edges clear ready; frozen keeps it
  always_comb begin
    ready_nxt = ready_r;
    if (hold_set || hold_clr)
      ready_nxt = 1'b0;
    else if (ctl_r.capture_hold)
      ready_nxt = ready_r;
    // early ready as soon as all enabled ports are in
    else if (cfg_r.early_ready_select)
      ready_nxt = ready_r | all_done;
    // normal ready at next frame edge after completion
    else
      ready_nxt = ready_r | (all_done && |(edge_hit & en));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ready_r <= 1'b0;
    else
      ready_r <= ready_nxt;
  end

  // ==========================================================
  // interrupt status, mask and output
  // bit 2 ready rising, bits 1:0 port captures
  assign irq_ev = {ready_nxt && !ready_r, cap};

  // read clears, a same-cycle event wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irq_sts_r <= '0;
    else if (rd_take && hit(s_axi_araddr, ts_pkg::IDX_IRQ_STS))
      irq_sts_r <= irq_ev;
    else
      irq_sts_r <= irq_sts_r | irq_ev;
  end

  // registered so irq comes straight from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_sts_r & irq_mask_r);
  end

  // ==========================================================
  // read data selection
  always_comb begin
    rd_byte = 8'h00;
    unique case (s_axi_araddr[9:2])
      ts_pkg::IDX_CONFIG:   rd_byte = cfg_r;
      ts_pkg::IDX_CONTROL:  rd_byte = ctl_r;
      ts_pkg::IDX_LINE_HI:  rd_byte = line_hi_r;
      ts_pkg::IDX_LINE_LO:  rd_byte = line_lo_r;
      ts_pkg::IDX_STATUS:   rd_byte = {3'b000, ready_r, 2'b00, valid_r};
      ts_pkg::IDX_TS_P0_HI: rd_byte = ts_r[0][15:8];
      ts_pkg::IDX_TS_P0_LO: rd_byte = ts_r[0][7:0];
      ts_pkg::IDX_TS_P1_HI: rd_byte = ts_r[1][15:8];
      ts_pkg::IDX_TS_P1_LO: rd_byte = ts_r[1][7:0];
      // interrupt status and mask, zero extended
      ts_pkg::IDX_IRQ_STS:  rd_byte = 8'(irq_sts_r);
      ts_pkg::IDX_IRQ_MASK: rd_byte = 8'(irq_mask_r);
      default:              rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // axi4-lite read channel
  // answer follows one cycle after the take
  assign rd_take = s_axi_arvalid && s_axi_arready;

  // data registered one cycle after the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ts_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      // unmapped: zero data, error answered
      s_axi_rresp   <= mapped(s_axi_araddr) ? ts_pkg::RESP_OKAY
                                            : ts_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule

// ---- include/ts_pkg.sv ----
// constants and types shared by the timestamp capture unit
package ts_pkg;

  // ==========================================================
  // bus and register map (register index, byte address = 4x)
  localparam int          ADDR_W       = 10;
  localparam int          NUM_PORTS    = 2;
  localparam logic [7:0]  IDX_CONFIG   = 8'h25;
  localparam logic [7:0]  IDX_CONTROL  = 8'h26;
  localparam logic [7:0]  IDX_LINE_HI  = 8'h27;
  localparam logic [7:0]  IDX_LINE_LO  = 8'h28;
  localparam logic [7:0]  IDX_STATUS   = 8'h29;
  localparam logic [7:0]  IDX_TS_P0_HI = 8'h2a;
  localparam logic [7:0]  IDX_TS_P0_LO = 8'h2b;
  localparam logic [7:0]  IDX_TS_P1_HI = 8'h2c;
  localparam logic [7:0]  IDX_TS_P1_LO = 8'h2d;
  localparam logic [7:0]  IDX_IRQ_STS  = 8'h40;
  localparam logic [7:0]  IDX_IRQ_MASK = 8'h41;

  // ==========================================================
  // reset values and writable bits
  localparam logic [7:0]  CONFIG_RST     = 8'h00;
  localparam logic [7:0]  CONTROL_RST    = 8'h00;
  localparam logic [7:0]  LINE_RST       = 8'h00;
  localparam logic [7:0]  IRQ_MASK_RST   = 8'h00;
  localparam logic [7:0]  CONFIG_WMASK   = 8'h7b;
  localparam logic [7:0]  CONTROL_WMASK  = 8'h13;
  localparam logic [7:0]  IRQ_WMASK      = 8'h07;
  localparam int          HOLD_BIT       = 4;
  localparam int          READY_BIT      = 4;
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_READY      = 2;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // ==========================================================
  // timing: tick periods in ns, derived cycle counts
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK0_NS      = 40;
  localparam int TICK1_NS      = 80;
  localparam int TICK2_NS      = 160;
  localparam int TICK3_NS      = 1000;
  localparam int TICK0_CYC     = TICK0_NS * 1000 / CLK_PERIOD_PS;
  localparam int TICK1_CYC     = TICK1_NS * 1000 / CLK_PERIOD_PS;
  localparam int TICK2_CYC     = TICK2_NS * 1000 / CLK_PERIOD_PS;
  localparam int TICK3_CYC     = TICK3_NS * 1000 / CLK_PERIOD_PS;

  // ==========================================================
  // register layouts
  typedef struct packed {
    logic       rsv7;
    logic       sync_edge_select;
    logic [1:0] tick_period_select;
    logic       early_ready_select;
    logic       rsv2;
    logic       free_running_select;
    logic       capture_trigger_select;
  } cfg_s;

  typedef struct packed {
    logic [2:0] rsv7_5;
    logic       capture_hold;
    logic [1:0] rsv3_2;
    logic       port1_capture_enable;
    logic       port0_capture_enable;
  } ctl_s;

endpackage

// ---- logic/tick_counter.sv ----
// timestamp counter advancing at the selected tick period
`timescale 1ns/1ps
module tick_counter #(
  parameter int TS_W = 16
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic [1:0]      tick_period_select,
  output logic      [TS_W-1:0] ts_value
);

  logic [7:0] div_r;
  logic [7:0] div_last;

  always_comb begin
    unique case (tick_period_select)
      2'b00:   div_last = 8'(ts_pkg::TICK0_CYC - 1);
      2'b01:   div_last = 8'(ts_pkg::TICK1_CYC - 1);
      2'b10:   div_last = 8'(ts_pkg::TICK2_CYC - 1);
      default: div_last = 8'(ts_pkg::TICK3_CYC - 1);
    endcase
  end

  // advance once per tick, wrap to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r    <= 8'h00;
      ts_value <= '0;
    end else if (div_r >= div_last) begin
      div_r    <= 8'h00;
      ts_value <= ts_value + 1'b1;
    end else begin
      div_r    <= div_r + 8'h01;
    end
  end

endmodule

// ---- logic/port_capture.sv ----
// per-port trigger: line counting, sync edge and arming
`timescale 1ns/1ps
module port_capture (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        frame_sync,
  input  wire logic        line_start,
  input  wire logic        enable,
  input  wire logic        sync_edge_select,
  input  wire logic        capture_trigger_select,
  input  wire logic        free_running_select,
  input  wire logic [15:0] capture_line,
  output logic             trig,
  output logic             sync_edge
);

  logic        sync_prev_r;
  logic [15:0] line_cnt_r;
  logic [15:0] line_inc;
  logic        line_hit;
  logic        armed_r;

  assign sync_edge = sync_edge_select ? (sync_prev_r & ~frame_sync)
                                      : (~sync_prev_r & frame_sync);
  assign line_inc  = line_cnt_r + 16'h0001;
  assign line_hit  = line_start && (line_inc == capture_line);

  // line or frame trigger; free run waits for line
  always_comb begin
    if (!enable)
      trig = 1'b0;
    else if (!capture_trigger_select)
      trig = line_hit;
    else if (free_running_select)
      trig = sync_edge && armed_r;
    else
      trig = sync_edge;
  end

  // line counter restarts on each active sync edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_r <= 1'b0;
      line_cnt_r  <= 16'h0000;
    end else begin
      sync_prev_r <= frame_sync;
      if (sync_edge)
        line_cnt_r <= 16'h0000;
      else if (line_start && line_cnt_r != 16'hffff)
        line_cnt_r <= line_inc;
    end
  end

  // arm at programmed line, disarm on capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      armed_r <= 1'b0;
    else if (!enable || trig)
      armed_r <= 1'b0;
    else if (line_hit)
      armed_r <= 1'b1;
  end

endmodule

// ---- verification/ts_capture_properties.sv ----
// bus-side assertions for the timestamp capture unit
`timescale 1ns/1ps
module ts_capture_properties #(
  parameter int TS_W = 16
) (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic [1:0]                s_axi_bresp,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic [ts_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic [1:0]                s_axi_rresp,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic                      irq
);
  logic [7:0] ridx_r;
  logic       mapped;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // index of the read in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ridx_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ridx_r <= s_axi_araddr[9:2];
  end
  assign mapped = ridx_r inside {[ts_pkg::IDX_CONFIG:ts_pkg::IDX_TS_P1_LO],
                                 ts_pkg::IDX_IRQ_STS, ts_pkg::IDX_IRQ_MASK};

  // ==========================================================
  // write and read answer timing, read data and response codes
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> !s_axi_bvalid ##2 s_axi_bvalid) else $error("write answer late");
  a_bvalid_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_write_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rdata_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  a_byte_wide: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_reserved_zero: assert property (
    s_axi_rvalid && ridx_r == ts_pkg::IDX_STATUS
    |-> s_axi_rdata[7:5] == 3'h0 && s_axi_rdata[3:2] == 2'h0)
    else $error("status reserved bits set");
  a_mapped_okay: assert property (
    s_axi_rvalid |-> (mapped ? s_axi_rresp == ts_pkg::RESP_OKAY
                             : s_axi_rresp == ts_pkg::RESP_SLVERR))
    else $error("read response code wrong");

  // main scenarios reached
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp[1]);
  c_irq: cover property ($rose(irq));
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the timestamp capture unit
`timescale 1ns/1ps
module testbench;
  logic                      clk, rst_n, irq;
  logic [ts_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]               s_axi_wdata, s_axi_rdata;
  logic [3:0]                s_axi_wstrb;
  logic [1:0]                s_axi_bresp, s_axi_rresp, frame_sync, line_start;
  logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                      s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                      s_axi_arvalid, s_axi_arready;
  logic                      s_axi_rvalid, s_axi_rready;
  int                        miscompares, cmp_count, seed, tc;
  logic [17:0]               rq[$];
  logic [1:0]                bq[$];
  logic [17:0]               rn;
  logic [7:0]                v, c;
  logic [15:0]               t0, t1;
  int                        tick_ns[4] = '{40, 80, 160, 1000};
  logic [7:0]                cfgs[6] = '{8'h00, 8'h58, 8'h21, 8'h71,
                                         8'h0b, 8'h43};

  timestamp_capture #(.TS_W(16)) dut (.clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .frame_sync, .line_start, .irq);

  // ==========================================================
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // checking and closing
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      miscompares++;
      end_of_test();
    end
  endtask

  // ==========================================================
  // bus master tasks
  task automatic wr(logic [7:0] idx, logic [7:0] d,
                    logic [1:0] er = ts_pkg::RESP_OKAY);
    int   n;
    logic a, w, b;
    n = 0;
    @(posedge clk);
    bq.push_back(er);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge clk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      @(posedge clk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      guard(n);
    end while (!b);
  endtask

  task automatic rd(logic [7:0] idx, logic [7:0] e, logic [7:0] m = 8'hff,
                    logic [1:0] er = ts_pkg::RESP_OKAY);
    int   n;
    logic a, r;
    n = 0;
    @(posedge clk);
    rq.push_back({m, e, er});
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clk);
      a = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid && s_axi_rready;
      if (r) v = s_axi_rdata[7:0];
      @(posedge clk);
      if (a) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
      guard(n);
    end while (!r);
  endtask

  // two line pulses, then an inactive and an active sync edge
  task automatic ev(int p, logic pol);
    line_start[p] <= 1'b1;
    @(posedge clk);
    line_start[p] <= 1'b0;
    @(posedge clk);
    line_start[p] <= 1'b1;
    @(posedge clk);
    line_start[p] <= 1'b0;
    frame_sync[p] <= pol;
    @(posedge clk);
    frame_sync[p] <= ~pol;
    @(posedge clk);
  endtask

  // ==========================================================
  // monitor: oldest note against each answer
  always @(negedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      rn = rq.pop_front();
      chk("rdata", rn[9:2], s_axi_rdata[7:0] & rn[17:10]);
      chk("rresp", rn[1:0], s_axi_rresp);
    end
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", bq.pop_front(), s_axi_bresp);
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h6866_47c7;
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, frame_sync, line_start} = 6'h00;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 'h25; i <= 'h2d; i++) rd(8'(i), 8'h00);
    rd(ts_pkg::IDX_IRQ_MASK, 8'h00);
    rd(8'h30, 8'h00, 8'hff, ts_pkg::RESP_SLVERR);
    wr(8'h30, 8'h5a, ts_pkg::RESP_SLVERR);
    wr(ts_pkg::IDX_STATUS, 8'hff);
    rd(ts_pkg::IDX_STATUS, 8'h00);
    v = 8'($random(seed));
    wr(ts_pkg::IDX_LINE_HI, v);
    rd(ts_pkg::IDX_LINE_HI, v);
    s_axi_wstrb <= 4'h0;
    wr(ts_pkg::IDX_LINE_HI, 8'hff);
    s_axi_wstrb <= 4'h1;
    rd(ts_pkg::IDX_LINE_HI, v);
    v = 8'($random(seed));
    wr(ts_pkg::IDX_LINE_LO, v);
    rd(ts_pkg::IDX_LINE_LO, v);
    wr(ts_pkg::IDX_LINE_HI, 8'h00);
    wr(ts_pkg::IDX_LINE_LO, 8'h02);
    for (int i = 0; i < 6; i++) begin
      c = cfgs[i];
      tc = tick_ns[c[5:4]] / 5; // cycles of 5 ns per count
      wr(ts_pkg::IDX_CONFIG, c | 8'h84);
      rd(ts_pkg::IDX_CONFIG, c);
      wr(ts_pkg::IDX_CONTROL, 8'h03);
      frame_sync <= {2{c[6]}};
      repeat (3) @(posedge clk);
      frame_sync <= {2{~c[6]}};
      repeat (3) @(posedge clk);
      ev(0, c[6]);
      repeat (5 * tc - 5) @(posedge clk);
      ev(1, c[6]);
      repeat (4) @(posedge clk);
      if (!c[0] || c[3]) rd(ts_pkg::IDX_STATUS, 8'h13);
      if (i == 0) begin
        @(negedge clk);
        chk("irq", 16'h0000, irq);
        wr(ts_pkg::IDX_IRQ_MASK, 8'h07);
        @(negedge clk);
        chk("irq", 16'h0001, irq);
        rd(ts_pkg::IDX_IRQ_STS, 8'h07);
        repeat (2) @(negedge clk);
        chk("irq", 16'h0000, irq);
      end
      wr(ts_pkg::IDX_CONTROL, 8'h13);
      rd(ts_pkg::IDX_STATUS, 8'h03);
      rd(ts_pkg::IDX_TS_P0_HI, 8'h00, 8'h00);
      t0[15:8] = v;
      rd(ts_pkg::IDX_TS_P0_LO, 8'h00, 8'h00);
      t0[7:0] = v;
      rd(ts_pkg::IDX_TS_P1_HI, 8'h00, 8'h00);
      t1[15:8] = v;
      rd(ts_pkg::IDX_TS_P1_LO, 8'h00, 8'h00);
      t1[7:0] = v;
      chk("ts delta", 16'h0005, t1 - t0);
      ev(0, c[6]);
      rd(ts_pkg::IDX_TS_P0_LO, t0[7:0]);
      wr(ts_pkg::IDX_CONTROL, 8'h03);
      rd(ts_pkg::IDX_STATUS, 8'h00);
    end
    wr(ts_pkg::IDX_CONFIG, 8'h00);
    wr(ts_pkg::IDX_CONTROL, 8'h01);
    ev(1, 1'b0);
    rd(ts_pkg::IDX_STATUS, 8'h00);
    end_of_test();
  end
endmodule

bind timestamp_capture ts_capture_properties #(.TS_W(TS_W)) props (.clk,
  .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq);
